// [rap_dev.sv]
// Device end: serial command decoder over a 128-byte register page
// Notes on behaviour
// - Port-select 'b10 at reset or boot enables
// - Frame is start, eight data, stop, no parity
// - Align on start edge, sample bit midpoints
// - Fractional divider makes 16x sample tick
// - Step gives M, span gives N minus M
// - Rate bytes loadable by boot or link
// - New rate applied only when port idle
// - Reset rate: step 4, span 2021
// - Step 16, span 659 gives exact rate
// - Host sends zero, cmd, addresses, length, data
// - Command bits 5:4 select nop, read, write
// - Command bit 1 low auto-increments address
// - Command bit 0 requests acknowledge byte
// - Read returns length bytes, then 0x5A if bit 0 is set
// - Burst stays below page pointer at 127
// - High address byte ignored, low used
// - Double-address flag clear skips high byte
// - No serial response during boot load
`timescale 1ns/1ps
module rap_dev
	import rap_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	rap_link_if.dev         link,
	input  wire logic [1:0] port_sel,
	input  wire logic       boot_busy,
	input  wire logic       boot_we,
	input  wire logic [6:0] boot_addr,
	input  wire logic [7:0] boot_wdata,
	input  wire logic       boot_sel_we,
	input  wire logic [1:0] boot_sel,
	output logic            uart_mode,
	output logic            port_idle
);
	typedef struct packed {
		rap_dev_e         st;
		logic             sel_done;
		logic             uart_on;
		logic             idle;
		logic [7:0]       cmd;
		logic [6:0]       addr;
		logic [7:0]       cnt;
		logic [16:0]      acc;
		logic [7:0]       m_act;
		logic [16:0]      n_act;
		rap_rx_s          rx;
		rap_tx_s          tx;
		logic [127:0][7:0] mem;
	} rap_dev_s;

	rap_dev_s cur;
	rap_dev_s next_cur;

	function automatic rap_dev_s rap_dev_reset();
		rap_dev_s r;
		r = '0;
		r.st = D_BOOT;
		r.rx = RAP_RX_RST;
		r.tx = RAP_TX_RST;
		r.mem[RAP_STEP_LO] = RAP_STEP_RST[7:0];
		r.mem[RAP_STEP_HI] = {4'h0, RAP_STEP_RST[11:8]};
		r.mem[RAP_SPAN_LO] = RAP_SPAN_RST[7:0];
		r.mem[RAP_SPAN_HI] = RAP_SPAN_RST[15:8];
		r.m_act = RAP_STEP_RST[7:0];
		r.n_act = {1'b0, RAP_SPAN_RST} + {9'h000, RAP_STEP_RST[7:0]};
		return r;
	endfunction

	// With the fixed-address bit set a burst keeps touching one register
	function automatic logic [6:0] rap_step_addr(input logic [6:0] a, input logic [7:0] c);
		return c[RAP_FIX_BIT] ? a : a + 7'h01;
	endfunction

	function automatic rap_dev_e rap_finish(input logic [7:0] c);
		return c[RAP_ACK_BIT] ? D_ACK : D_ZERO;
	endfunction

	logic       tick;
	logic       load;
	logic [7:0] ldata;
	logic [1:0] op;
	logic       listen;

	always_comb begin
		next_cur = cur;
		load = 1'b0;
		ldata = RAP_ZERO_BYTE;
		op = cur.cmd[RAP_OP_HI:RAP_OP_LO];
		if (!cur.sel_done) begin
			next_cur.sel_done = 1'b1;
			next_cur.uart_on = (port_sel == RAP_SEL_UART);
		end
		if (boot_sel_we) begin
			next_cur.uart_on = (boot_sel == RAP_SEL_UART);
		end
		if (boot_we) begin
			next_cur.mem[boot_addr] = boot_wdata;
		end
		{tick, next_cur.acc} = rap_div_step(cur.acc, cur.m_act, cur.n_act);
		// Line is masked while booting so no stray frame is half-received at the hand-over
		listen = (cur.st != D_BOOT);
		next_cur.rx = rap_rx_step(cur.rx, tick, link.h2d | !listen);
		unique case (cur.st)
			D_BOOT: begin
				if (cur.sel_done && cur.uart_on && !boot_busy) begin
					next_cur.st = D_ZERO;
				end
			end
			D_ZERO: begin
				// Anything but a zero byte here is line noise and is dropped
				if (cur.rx.done && cur.rx.sh == RAP_ZERO_BYTE) begin
					next_cur.st = D_CMD;
				end
			end
			D_CMD: begin
				if (cur.rx.done) begin
					next_cur.cmd = cur.rx.sh;
					next_cur.st = cur.mem[RAP_STEP_HI][RAP_DBL_BIT] ? D_AHI : D_ALO;
				end
			end
			D_AHI: begin
				if (cur.rx.done) begin
					next_cur.st = D_ALO;
				end
			end
			D_ALO: begin
				if (cur.rx.done) begin
					next_cur.addr = cur.rx.sh[6:0];
					next_cur.st = D_LEN;
				end
			end
			D_LEN: begin
				if (cur.rx.done) begin
					next_cur.cnt = cur.rx.sh;
					// A zero length turns a read or write into a no-operation
					if (op == RAP_OP_WRITE && cur.rx.sh != RAP_ZERO_BYTE) begin
						next_cur.st = D_WDATA;
					end else if (op == RAP_OP_READ && cur.rx.sh != RAP_ZERO_BYTE) begin
						next_cur.st = D_RDATA;
					end else begin
						next_cur.st = rap_finish(cur.cmd);
					end
				end
			end
			D_WDATA: begin
				if (cur.rx.done) begin
					next_cur.mem[cur.addr] = cur.rx.sh;
					next_cur.addr = rap_step_addr(cur.addr, cur.cmd);
					next_cur.cnt = cur.cnt - 8'h01;
					if (cur.cnt == 8'h01) begin
						next_cur.st = rap_finish(cur.cmd);
					end
				end
			end
			D_RDATA: begin
				// Next byte is queued as soon as the transmitter frees, so reads stream back to back
				if (!cur.tx.busy) begin
					load = 1'b1;
					ldata = cur.mem[cur.addr];
					next_cur.addr = rap_step_addr(cur.addr, cur.cmd);
					next_cur.cnt = cur.cnt - 8'h01;
					if (cur.cnt == 8'h01) begin
						next_cur.st = rap_finish(cur.cmd);
					end
				end
			end
			D_ACK: begin
				if (!cur.tx.busy) begin
					load = 1'b1;
					ldata = RAP_ACK_BYTE;
					next_cur.st = D_ZERO;
				end
			end
		endcase
		// Leaving serial mode drops a command in progress; a frame already on the wire still ends
		if (cur.sel_done && !cur.uart_on) begin
			next_cur.st = D_BOOT;
		end
		next_cur.tx = rap_tx_step(cur.tx, tick, load, ldata);
		next_cur.idle = (cur.st == D_ZERO) && !cur.rx.busy && !cur.tx.busy && !load;
		// Switching rate mid-frame would corrupt the byte in flight, so wait for idle
		if (next_cur.idle) begin
			next_cur.m_act = cur.mem[RAP_STEP_LO];
			next_cur.n_act = {1'b0, cur.mem[RAP_SPAN_HI], cur.mem[RAP_SPAN_LO]} +
				{9'h000, cur.mem[RAP_STEP_LO]};
			// A shorter divisor could leave the accumulator above it and tick on every clock
			if (next_cur.acc >= next_cur.n_act) begin
				next_cur.acc = '0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur <= rap_dev_reset();
		end else begin
			cur <= next_cur;
		end
	end

	assign link.d2h = cur.tx.line;
	assign uart_mode = cur.uart_on;
	assign port_idle = cur.idle;
endmodule

// [rap_host.sv]
// Host end: command master driven from a small software register port
`timescale 1ns/1ps
module rap_host
	import rap_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	rap_link_if.host        link,
	input  wire logic [7:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic [7:0]      sw_rdata,
	output logic            host_busy
);
	typedef struct packed {
		rap_host_e         st;
		logic [2:0]        hidx;
		logic [7:0]        cnt;
		logic [6:0]        bidx;
		logic [7:0]        cmd;
		logic [7:0]        addr;
		logic [7:0]        len;
		logic [7:0]        step;
		logic [15:0]       span;
		logic              dbl;
		logic              ack_ok;
		logic              err;
		logic              busy;
		logic [7:0]        rdata;
		logic [16:0]       acc;
		logic [7:0]        m_act;
		logic [16:0]       n_act;
		rap_rx_s           rx;
		rap_tx_s           tx;
		logic [127:0][7:0] buff;
	} rap_host_s;

	rap_host_s cur;
	rap_host_s next_cur;

	function automatic rap_host_s rap_host_reset();
		rap_host_s r;
		r = '0;
		r.st = H_IDLE;
		r.rx = RAP_RX_RST;
		r.tx = RAP_TX_RST;
		r.step = RAP_STEP_RST[7:0];
		r.span = RAP_SPAN_RST;
		r.dbl = RAP_STEP_RST[8];
		r.m_act = RAP_STEP_RST[7:0];
		r.n_act = {1'b0, RAP_SPAN_RST} + {9'h000, RAP_STEP_RST[7:0]};
		return r;
	endfunction

	function automatic rap_host_e rap_finish(input logic [7:0] c);
		return c[RAP_ACK_BIT] ? H_ACK : H_IDLE;
	endfunction

	logic       tick;
	logic       load;
	logic [7:0] ldata;
	logic [1:0] op;
	logic [7:0] hbyte;

	always_comb begin
		next_cur = cur;
		load = 1'b0;
		ldata = RAP_ZERO_BYTE;
		op = cur.cmd[RAP_OP_HI:RAP_OP_LO];
		unique case (cur.hidx)
			3'h1: hbyte = cur.cmd;
			3'h3: hbyte = cur.addr;
			3'h4: hbyte = cur.len;
			default: hbyte = RAP_ZERO_BYTE;
		endcase
		if (sw_rd) begin
			if (sw_addr[RAP_H_BUF_BIT]) begin
				next_cur.rdata = cur.buff[sw_addr[6:0]];
			end else begin
				unique case (sw_addr)
					RAP_H_CMD:     next_cur.rdata = cur.cmd;
					RAP_H_ADDR:    next_cur.rdata = cur.addr;
					RAP_H_LEN:     next_cur.rdata = cur.len;
					RAP_H_STATUS:  next_cur.rdata = {5'h00, cur.err, cur.ack_ok, cur.busy};
					RAP_H_STEP:    next_cur.rdata = cur.step;
					RAP_H_SPAN_LO: next_cur.rdata = cur.span[7:0];
					RAP_H_SPAN_HI: next_cur.rdata = cur.span[15:8];
					RAP_H_OPTS:    next_cur.rdata = {7'h00, cur.dbl};
					default:       next_cur.rdata = RAP_ZERO_BYTE;
				endcase
			end
		end
		if (sw_wr) begin
			if (sw_addr[RAP_H_BUF_BIT]) begin
				next_cur.buff[sw_addr[6:0]] = sw_wdata;
			end else begin
				unique case (sw_addr)
					RAP_H_CMD:     next_cur.cmd = sw_wdata;
					RAP_H_ADDR:    next_cur.addr = sw_wdata;
					RAP_H_LEN:     next_cur.len = sw_wdata;
					RAP_H_STEP:    next_cur.step = sw_wdata;
					RAP_H_SPAN_LO: next_cur.span[7:0] = sw_wdata;
					RAP_H_SPAN_HI: next_cur.span[15:8] = sw_wdata;
					RAP_H_OPTS:    next_cur.dbl = sw_wdata[0];
					default:       next_cur.st = cur.st;
				endcase
			end
		end
		{tick, next_cur.acc} = rap_div_step(cur.acc, cur.m_act, cur.n_act);
		next_cur.rx = rap_rx_step(cur.rx, tick, link.d2h);
		unique case (cur.st)
			H_IDLE: begin
				if (sw_wr && sw_addr == RAP_H_CTRL && sw_wdata[0]) begin
					// A burst reaching 0x7E, the byte below the page pointer, is refused outright
					if ({1'b0, cur.addr} + {1'b0, cur.len} >= {1'b0, RAP_PAGE_TOP}) begin
						next_cur.err = 1'b1;
					end else begin
						next_cur.err = 1'b0;
						next_cur.ack_ok = 1'b0;
						next_cur.st = H_HDR;
						next_cur.hidx = 3'h0;
						next_cur.bidx = 7'h00;
						next_cur.cnt = cur.len;
					end
				end
			end
			H_HDR: begin
				if (!cur.tx.busy) begin
					load = 1'b1;
					ldata = hbyte;
					next_cur.hidx = (cur.hidx == 3'h1 && !cur.dbl) ? 3'h3 : cur.hidx + 3'h1;
					if (cur.hidx == 3'h4) begin
						if (op == RAP_OP_WRITE && cur.len != RAP_ZERO_BYTE) begin
							next_cur.st = H_WDATA;
						end else if (op == RAP_OP_READ && cur.len != RAP_ZERO_BYTE) begin
							next_cur.st = H_RDATA;
						end else begin
							next_cur.st = rap_finish(cur.cmd);
						end
					end
				end
			end
			H_WDATA: begin
				if (!cur.tx.busy) begin
					load = 1'b1;
					ldata = cur.buff[cur.bidx];
					next_cur.bidx = cur.bidx + 7'h01;
					next_cur.cnt = cur.cnt - 8'h01;
					if (cur.cnt == 8'h01) begin
						next_cur.st = rap_finish(cur.cmd);
					end
				end
			end
			H_RDATA: begin
				if (cur.rx.done) begin
					next_cur.buff[cur.bidx] = cur.rx.sh;
					next_cur.bidx = cur.bidx + 7'h01;
					next_cur.cnt = cur.cnt - 8'h01;
					if (cur.cnt == 8'h01) begin
						next_cur.st = rap_finish(cur.cmd);
					end
				end
			end
			H_ACK: begin
				if (cur.rx.done) begin
					next_cur.ack_ok = (cur.rx.sh == RAP_ACK_BYTE);
					next_cur.st = H_IDLE;
				end
			end
		endcase
		next_cur.tx = rap_tx_step(cur.tx, tick, load, ldata);
		next_cur.busy = (next_cur.st != H_IDLE) || next_cur.tx.busy;
		if (cur.st == H_IDLE && !cur.tx.busy && !cur.rx.busy) begin
			next_cur.m_act = cur.step;
			next_cur.n_act = {1'b0, cur.span} + {9'h000, cur.step};
			// A shorter divisor could leave the accumulator above it and tick on every clock
			if (next_cur.acc >= next_cur.n_act) begin
				next_cur.acc = '0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur <= rap_host_reset();
		end else begin
			cur <= next_cur;
		end
	end

	assign link.h2d = cur.tx.line;
	assign sw_rdata = cur.rdata;
	assign host_busy = cur.busy;
endmodule

// [rap_link_chk.sv]
// Checker of the two serial wires between the host and device ends
`timescale 1ns/1ps
module rap_link_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic h2d,
	input wire logic d2h
);
	// Fastest bit used is 32 clocks; one tick of jitter at each end is allowed
	localparam int RUN_MIN = 28;
	// Nine low bits at the slowest rate exercised; a 9600 baud run would exceed it
	localparam int LOW_MAX = 6200;
	logic        h_prev;
	logic        d_prev;
	logic [15:0] h_run;
	logic [15:0] d_run;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			h_prev <= 1'b1;
			d_prev <= 1'b1;
			h_run  <= 16'hFFFF;
			d_run  <= 16'hFFFF;
		end else begin
			h_prev <= h2d;
			d_prev <= d2h;
			h_run  <= (h2d != h_prev) ? 16'h0001 : ((h_run == 16'hFFFF) ? h_run : h_run + 16'h0001);
			d_run  <= (d2h != d_prev) ? 16'h0001 : ((d_run == 16'hFFFF) ? d_run : d_run + 16'h0001);
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_idle_rel; $rose(rst_n) |-> h2d && d2h; endproperty
	a_idle_rel: assert property (p_idle_rel) else $error("Lines not idle high after reset");
	property p_h_run_min; h2d != h_prev |-> h_run >= RUN_MIN; endproperty
	a_h_run_min: assert property (p_h_run_min) else $error("Host line level shorter than a bit");
	property p_d_run_min; d2h != d_prev |-> d_run >= RUN_MIN; endproperty
	a_d_run_min: assert property (p_d_run_min) else $error("Device line level shorter than a bit");
	property p_h_low_max; $rose(h2d) |-> h_run <= LOW_MAX; endproperty
	a_h_low_max: assert property (p_h_low_max) else $error("Host line low past the stop bit");
	property p_d_low_max; $rose(d2h) |-> d_run <= LOW_MAX; endproperty
	a_d_low_max: assert property (p_d_low_max) else $error("Device line low past the stop bit");
	property p_h_start; $fell(h2d) |=> !h2d [*8]; endproperty
	a_h_start: assert property (p_h_start) else $error("Host start bit cut short");
	property p_d_start; $fell(d2h) |=> !d2h [*8]; endproperty
	a_d_start: assert property (p_d_start) else $error("Device start bit cut short");
	property p_half_dup; !d2h |-> h2d; endproperty
	a_half_dup: assert property (p_half_dup) else $error("Device sent before command ended");

	c_dev_frame: cover property ($fell(d2h));
	c_host_frame: cover property ($fell(h2d));
	c_slow_bit: cover property ($rose(d2h) && d_run > 16'h0BB8);
endmodule

// [rap_link_if.sv]
// Two-wire serial link between the host controller and the device port
`timescale 1ns/1ps
interface rap_link_if;
	logic h2d;
	logic d2h;
	modport dev  (input h2d, output d2h);
	modport host (output h2d, input d2h);
endinterface

// [rap_pkg.sv]
// Shared constants, types and serial framing functions for the register access port
package rap_pkg;
	localparam logic [1:0]  RAP_SEL_UART    = 2'b10;
	localparam logic [1:0]  RAP_OP_NOP      = 2'b00;
	localparam logic [1:0]  RAP_OP_READ     = 2'b01;
	localparam logic [1:0]  RAP_OP_WRITE    = 2'b10;
	localparam int          RAP_OP_HI       = 5;
	localparam int          RAP_OP_LO       = 4;
	localparam int          RAP_FIX_BIT     = 1;
	localparam int          RAP_ACK_BIT     = 0;
	localparam logic [7:0]  RAP_ACK_BYTE    = 8'h5A;
	localparam logic [7:0]  RAP_ZERO_BYTE   = 8'h00;
	localparam logic [7:0]  RAP_PAGE_TOP    = 8'h7F;
	// Rate registers inside the device page: step low, step high, span low, span high
	localparam logic [6:0]  RAP_STEP_LO     = 7'h10;
	localparam logic [6:0]  RAP_STEP_HI     = 7'h11;
	localparam logic [6:0]  RAP_SPAN_LO     = 7'h12;
	localparam logic [6:0]  RAP_SPAN_HI     = 7'h13;
	localparam int          RAP_DBL_BIT     = 0;
	localparam logic [11:0] RAP_STEP_RST    = 12'h104;
	localparam logic [15:0] RAP_SPAN_RST    = 16'h07E5;
	localparam logic [3:0]  RAP_MID_PHASE   = 4'h7;
	localparam logic [3:0]  RAP_LAST_PHASE  = 4'hF;
	localparam logic [3:0]  RAP_STOP_BIT    = 4'h9;
	localparam logic [3:0]  RAP_FRAME_BITS  = 4'hA;
	// Host software registers
	localparam logic [7:0]  RAP_H_CMD       = 8'h00;
	localparam logic [7:0]  RAP_H_ADDR      = 8'h01;
	localparam logic [7:0]  RAP_H_LEN       = 8'h02;
	localparam logic [7:0]  RAP_H_CTRL      = 8'h03;
	localparam logic [7:0]  RAP_H_STATUS    = 8'h04;
	localparam logic [7:0]  RAP_H_STEP      = 8'h05;
	localparam logic [7:0]  RAP_H_SPAN_LO   = 8'h06;
	localparam logic [7:0]  RAP_H_SPAN_HI   = 8'h07;
	localparam logic [7:0]  RAP_H_OPTS      = 8'h08;
	localparam int          RAP_H_BUF_BIT   = 7;

	typedef enum logic [8:0] {
		D_BOOT  = 9'h001, D_ZERO = 9'h002, D_CMD = 9'h004, D_AHI = 9'h008, D_ALO = 9'h010,
		D_LEN   = 9'h020, D_WDATA = 9'h040, D_RDATA = 9'h080, D_ACK = 9'h100
	} rap_dev_e;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01, H_HDR = 5'h02, H_WDATA = 5'h04, H_RDATA = 5'h08, H_ACK = 5'h10
	} rap_host_e;

	typedef struct packed {
		logic       busy;
		logic       prev;
		logic       done;
		logic [3:0] phase;
		logic [3:0] bitn;
		logic [7:0] sh;
	} rap_rx_s;

	typedef struct packed {
		logic       busy;
		logic       line;
		logic [3:0] phase;
		logic [3:0] bitn;
		logic [9:0] sh;
	} rap_tx_s;

	localparam rap_rx_s RAP_RX_RST = '{busy: 1'b0, prev: 1'b1, done: 1'b0, phase: 4'h0, bitn: 4'h0, sh: 8'h00};
	localparam rap_tx_s RAP_TX_RST = '{busy: 1'b0, line: 1'b1, phase: 4'h0, bitn: 4'h0, sh: 10'h3FF};

	// Fractional divider: tick rate is clock * m / n; returns {tick, next accumulator}
	function automatic logic [17:0] rap_div_step(input logic [16:0] acc, input logic [7:0] m,
		input logic [16:0] n);
		logic [17:0] sum;
		sum = {1'b0, acc} + {10'h000, m};
		if (sum >= {1'b0, n}) begin
			rap_div_step = {1'b1, 17'(sum - {1'b0, n})};
		end else begin
			rap_div_step = {1'b0, sum[16:0]};
		end
	endfunction

	// Receiver on the 16x tick; a start edge re-zeroes the phase so each bit is taken mid-cell
	function automatic rap_rx_s rap_rx_step(input rap_rx_s s, input logic tick, input logic rxd);
		rap_rx_s n;
		n = s;
		n.done = 1'b0;
		n.prev = rxd;
		if (!s.busy) begin
			if (s.prev && !rxd) begin
				n.busy = 1'b1;
				n.phase = 4'h0;
				n.bitn = 4'h0;
			end
		end else if (tick) begin
			n.phase = s.phase + 4'h1;
			if (s.phase == RAP_MID_PHASE) begin
				n.bitn = s.bitn + 4'h1;
				if (s.bitn == 4'h0) begin
					n.busy = !rxd; // A glitch that is high again at mid-start is dropped
				end else if (s.bitn < RAP_STOP_BIT) begin
					n.sh = {rxd, s.sh[7:1]};
				end else begin
					n.busy = 1'b0;
					n.done = rxd; // Framing error: byte discarded
				end
			end
		end
		return n;
	endfunction

	function automatic rap_tx_s rap_tx_step(input rap_tx_s s, input logic tick, input logic load,
		input logic [7:0] data);
		rap_tx_s n;
		n = s;
		if (!s.busy) begin
			if (load) begin
				n.busy = 1'b1;
				n.sh = {1'b1, data, 1'b0};
				n.phase = 4'h0;
				n.bitn = 4'h0;
			end
		end else if (tick) begin
			n.phase = s.phase + 4'h1;
			if (s.phase == RAP_LAST_PHASE) begin
				n.sh = {1'b1, s.sh[9:1]};
				n.bitn = s.bitn + 4'h1;
				n.busy = (s.bitn + 4'h1) != RAP_FRAME_BITS;
			end
		end
		n.line = n.busy ? n.sh[0] : 1'b1;
		return n;
	endfunction
endpackage

// [uart_register_access_port_bench.sv]
// Self-checking bench joining the host and device ends over the serial link
`timescale 1ns/1ps
`define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
	$display("Error %s expected %0h seen %0h", name, exp, got); end end
module uart_register_access_port_bench import rap_pkg::*;;
	typedef struct packed {
		logic [7:0]      cmd;
		logic [7:0]      addr;
		logic [7:0]      len;
		logic [7:0]      base;
		logic            ack;
		logic [2:0][7:0] want;
	} rap_row_s;
	localparam rap_row_s ROWS [9] = '{
		'{8'h21, 8'h20, 8'h03, 8'hA1, 1'b1, 24'h000000},
		'{8'h11, 8'h20, 8'h03, 8'h00, 1'b1, 24'hA3A2A1},
		'{8'h23, 8'h30, 8'h02, 8'hB1, 1'b1, 24'h000000},
		'{8'h13, 8'h30, 8'h02, 8'h00, 1'b1, 24'h00B2B2},
		'{8'h10, 8'h20, 8'h01, 8'h00, 1'b0, 24'h0000A1},
		'{8'h01, 8'h00, 8'h00, 8'h00, 1'b1, 24'h000000},
		'{8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 24'h000000},
		'{8'hED, 8'h40, 8'h01, 8'hC1, 1'b1, 24'h000000},
		'{8'h11, 8'h40, 8'h01, 8'h00, 1'b1, 24'h0000C1}
	};
	// Divider bytes for 115200 baud: step 16, span 659
	localparam logic [3:0][7:0] NEW_RATE = 32'h02930110;
	logic       ref_clk     = 1'b0;
	logic       rst_n       = 1'b0;
	logic [1:0] port_sel    = 2'b10;
	logic       boot_busy   = 1'b1;
	logic       boot_we     = 1'b0;
	logic [6:0] boot_addr   = 7'h00;
	logic [7:0] boot_wdata  = 8'h00;
	logic       boot_sel_we = 1'b0;
	logic [1:0] boot_sel    = 2'b10;
	logic [7:0] sw_addr     = 8'h00;
	logic [7:0] sw_wdata    = 8'h00;
	logic       sw_wr       = 1'b0;
	logic       sw_rd       = 1'b0;
	logic [7:0] sw_rdata;
	logic       host_busy;
	logic       uart_mode;
	logic       port_idle;
	logic [7:0] rd;
	int         miscompares = 0;
	int         comparisons = 0;

	rap_link_if link ();
	rap_dev i_rap_dev (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.dev), .port_sel(port_sel),
		.boot_busy(boot_busy), .boot_we(boot_we), .boot_addr(boot_addr), .boot_wdata(boot_wdata),
		.boot_sel_we(boot_sel_we), .boot_sel(boot_sel), .uart_mode(uart_mode), .port_idle(port_idle));
	rap_host i_rap_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.host), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .host_busy(host_busy));
	rap_link_chk i_rap_link_chk (.ref_clk(ref_clk), .rst_n(rst_n), .h2d(link.h2d), .d2h(link.d2h));

	always #25 ref_clk = ~ref_clk;

	task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_wr    <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask

	task automatic sw_read(input logic [7:0] a);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd   <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		@(negedge ref_clk);
		rd = sw_rdata;
	endtask

	task automatic boot_write(input logic [6:0] a, input logic [7:0] d, input logic sel);
		@(posedge ref_clk);
		boot_addr   <= a;
		boot_wdata  <= d;
		boot_we     <= !sel;
		boot_sel    <= d[1:0];
		boot_sel_we <= sel;
		@(posedge ref_clk);
		boot_we     <= 1'b0;
		boot_sel_we <= 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic run_cmd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] n);
		sw_write(RAP_H_CMD, c);
		sw_write(RAP_H_ADDR, a);
		sw_write(RAP_H_LEN, n);
		sw_write(RAP_H_CTRL, 8'h01);
	endtask

	// Host and device must both be quiet, or the next command could meet a busy parser
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (4) @(negedge ref_clk);
		while ((host_busy !== 1'b0 || port_idle !== 1'b1) && n < 60000) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("wait_idle", 1'b1, n < 60000)
	endtask

	task automatic results;
		$display("Comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Expected run is about 70,000 clocks, most of it the one read at the slow rate
	initial begin
		#4500000;
		miscompares++;
		$display("Error watchdog expected finish seen hang");
		results();
	end

	initial begin
		int n;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Fast bench rate on both ends: M 4, N 8, one tick every two clocks
		boot_write(RAP_STEP_LO, 8'h04, 1'b0);
		boot_write(RAP_SPAN_LO, 8'h04, 1'b0);
		boot_write(RAP_SPAN_HI, 8'h00, 1'b0);
		@(posedge ref_clk);
		boot_busy <= 1'b0;
		sw_read(RAP_H_SPAN_HI);
		`CHK("span_hi_rst", 8'h07, rd)
		sw_read(RAP_H_SPAN_LO);
		`CHK("span_lo_rst", 8'hE5, rd)
		sw_write(RAP_H_STEP, 8'h04);
		sw_write(RAP_H_SPAN_LO, 8'h04);
		sw_write(RAP_H_SPAN_HI, 8'h00);
		`CHK("uart_mode", 1'b1, uart_mode)
		sw_read(8'h7F);
		`CHK("unmapped", 8'h00, rd)
		foreach (ROWS[r]) begin
			for (int i = 0; i < ROWS[r].len && ROWS[r].cmd[5:4] == RAP_OP_WRITE; i++) begin
				sw_write(8'h80 + 8'(i), ROWS[r].base + 8'(i));
			end
			run_cmd(ROWS[r].cmd, ROWS[r].addr, ROWS[r].len);
			wait_idle();
			sw_read(RAP_H_STATUS);
			`CHK("ack_ok", ROWS[r].ack, rd[1])
			for (int i = 0; i < ROWS[r].len && ROWS[r].cmd[5:4] == RAP_OP_READ; i++) begin
				sw_read(8'h80 + 8'(i));
				`CHK("read_byte", ROWS[r].want[i], rd)
			end
		end
		// A burst ending at 0x7E, just below the page pointer, must not leave the host
		run_cmd(8'h11, 8'h7D, 8'h02);
		repeat (4) @(negedge ref_clk);
		`CHK("h2d_quiet", 1'b1, link.h2d)
		sw_read(RAP_H_STATUS);
		`CHK("err", 1'b1, rd[2])
		// Single-byte addressing: the device flag is cleared over the link, then the host follows
		sw_write(8'h80, 8'h00);
		run_cmd(8'h21, {1'b0, RAP_STEP_HI}, 8'h01);
		wait_idle();
		sw_write(RAP_H_OPTS, 8'h00);
		run_cmd(8'h11, 8'h20, 8'h01);
		wait_idle();
		sw_read(RAP_H_STATUS);
		`CHK("short_ack", 1'b1, rd[1])
		sw_read(8'h80);
		`CHK("short_read", 8'hA1, rd)
		// The rate burst below goes out with one address byte and sets the flag again
		for (int i = 0; i < 4; i++) begin
			sw_write(8'h80 + 8'(i), NEW_RATE[i]);
		end
		run_cmd(8'h21, 8'h10, 8'h04);
		wait_idle();
		sw_read(RAP_H_STATUS);
		`CHK("rate_ack", 1'b1, rd[1])
		sw_write(RAP_H_OPTS, 8'h01);
		sw_write(RAP_H_STEP, 8'h10);
		sw_write(RAP_H_SPAN_LO, 8'h93);
		sw_write(RAP_H_SPAN_HI, 8'h02);
		run_cmd(8'h10, 8'h10, 8'h01);
		n = 0;
		while (link.d2h !== 1'b0 && n < 60000) begin
			@(negedge ref_clk);
			n++;
		end
		n = 0;
		while (link.d2h === 1'b0 && n < 8000) begin
			@(negedge ref_clk);
			n++;
		end
		// Start plus four zero bits of 0x10 is 80 ticks, 3375 clocks, one tick of slack
		`CHK("low_run", 1'b1, n > 3330 && n < 3420)
		wait_idle();
		sw_read(8'h80);
		`CHK("step_back", 8'h10, rd)
		boot_write(7'h00, 8'h00, 1'b1);
		`CHK("mode_off", 1'b0, uart_mode)
		repeat (2) @(negedge ref_clk);
		`CHK("idle_off", 1'b0, port_idle)
		boot_write(7'h00, 8'h02, 1'b1);
		`CHK("mode_on", 1'b1, uart_mode)
		repeat (2) @(negedge ref_clk);
		`CHK("idle_on", 1'b1, port_idle)
		results();
	end
endmodule
